// File: hdl/dacctl_consts.svh
// Constants for the DAC control port and mute block
`ifndef DACCTL_CONSTS_SVH
`define DACCTL_CONSTS_SVH
`define DACCTL_REG_LEFT 2'h0
`define DACCTL_REG_RIGHT 2'h1
`define DACCTL_REG_OUT 2'h2
`define DACCTL_REG_FMT 2'h3
`define DACCTL_ADDR_HI 10
`define DACCTL_ADDR_LO 9
`define DACCTL_COMMIT_BIT 8
`define DACCTL_WORD_BITS 16
`define DACCTL_ZERO_RUN 1024
`define DACCTL_LEVEL_RST 8'hff
`define DACCTL_ROUTE_RST 4'h9
`define DACCTL_WIDTH_16 2'h0
`define DACCTL_WIDTH_20 2'h1
`define DACCTL_WIDTH_24 2'h2
`define DACCTL_WIDTH_18 2'h3
`endif

// File: hdl/dacctl_pkg.sv
// Types shared by the DAC control block
package dacctl_pkg;
  typedef struct packed {
    logic soft_silence;
    logic deemph_enable;
    logic dac_disable;
    logic [1:0] sample_width;
    logic [3:0] output_routing;
  } dacctl_out_s;
  typedef struct packed {
    logic i2s_format;
    logic frame_polarity;
    logic shared_level;
    logic [1:0] rate_group;
    logic zero_detect_enable;
  } dacctl_fmt_s;
  typedef enum logic [1:0] {DACCTL_SEL_MUTE, DACCTL_SEL_LEFT, DACCTL_SEL_RIGHT, DACCTL_SEL_AVG} dacctl_route_e;
endpackage : dacctl_pkg

// File: hdl/dacctl_chan.sv
// One output channel: routing select and level scaling
module dacctl_chan
  import dacctl_pkg::*;
#(
  parameter int SW = 24
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Sources and controls
  input wire logic signed [SW-1:0] left_in,
  input wire logic signed [SW-1:0] right_in,
  input wire logic [1:0] sel,
  input wire logic [7:0] level,
  input wire logic silent,
  // Result
  output logic signed [SW-1:0] out_ff
);
  logic signed [SW:0] pick;
  logic signed [SW+9:0] prod;

  // Choose source: mute, left, right or average
  always_comb
  begin
    case (sel)
      2'h1: pick = {left_in[SW-1], left_in};
      2'h2: pick = {right_in[SW-1], right_in};
      2'h3: pick = ($signed({left_in[SW-1], left_in}) + $signed({right_in[SW-1], right_in})) >>> 1;
      default: pick = '0;
    endcase
    prod = pick * $signed({2'h0, level});
  end

  // Scale by level/256 and hold; silence forces zero
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      out_ff <= '0;
    else if (silent)
      out_ff <= '0;
    else if (level == 8'hff)
      out_ff <= pick[SW-1:0]; // Full code is unity gain
    else
      out_ff <= prod[SW+7:8];
  end
endmodule : dacctl_chan

// File: hdl/dacctl_top.sv
// Control port, register bank, mute and automute logic of the stereo DAC
`include "dacctl_consts.svh"
module dacctl_top
  import dacctl_pkg::*;
#(
  parameter int SW = 24,
  parameter int ZERO_RUN = `DACCTL_ZERO_RUN,
  parameter int RAMP_STEP_CYC = 78
)
(
  // System clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control pins (link clock is the shift clock pin)
  input wire logic ctl_clock_or_width_pin,
  input wire logic ctl_data_or_deemph_pin,
  input wire logic ctl_latch_or_format_pin,
  input wire logic mode_pin,
  input wire logic power_off_pin,
  // Mute pin, weak high drive or released
  input wire logic mute_pin_in,
  output logic mute_pin_out_ff,
  output logic mute_pin_oe_n_ff,
  // Audio samples, one strobe per stereo pair
  input wire logic sample_valid,
  input wire logic signed [SW-1:0] sample_left,
  input wire logic signed [SW-1:0] sample_right,
  input wire logic frame_sync,
  // Processed outputs
  output logic signed [SW-1:0] dac_left_ff,
  output logic signed [SW-1:0] dac_right_ff,
  output logic dac_midrail_ff,
  output logic powered_down_ff,
  output logic deemph_on_ff,
  output logic i2s_mode_ff,
  output logic [1:0] sample_width_ff,
  output logic [1:0] rate_group_ff,
  output logic left_is_high_ff,
  output logic automute_ff,
  output logic [7:0] silence_gain_ff
);
  // ****************************************
  // Link domain: shift register on shift clock
  // ****************************************
  logic [`DACCTL_WORD_BITS-1:0] shift_ff;
  logic [`DACCTL_WORD_BITS-1:0] word_ff;
  logic word_tgl_ff;

  // Shift data in MSB first on clock rise
  always_ff @(posedge ctl_clock_or_width_pin or posedge reset)
  begin
    if (reset)
      shift_ff <= '0;
    else
      shift_ff <= {shift_ff[`DACCTL_WORD_BITS-2:0], ctl_data_or_deemph_pin};
  end

  // Capture word and toggle on latch rise; software mode only
  always_ff @(posedge ctl_latch_or_format_pin or posedge reset)
  begin
    if (reset)
    begin
      word_ff <= '0;
      word_tgl_ff <= 1'b0;
    end
    else if (!mode_pin)
    begin
      word_ff <= shift_ff;
      word_tgl_ff <= ~word_tgl_ff;
    end
  end

  // ****************************************
  // Crossing into system clock domain
  // ****************************************
  logic [2:0] tgl_sync_ff;
  logic [1:0] mode_sync_ff, pwr_sync_ff, mute_sync_ff, lat_sync_ff, clk_sync_ff, dat_sync_ff;
  logic word_evt;

  // Two-stage synchronisers for the toggle and the pins
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      tgl_sync_ff <= '0;
      mode_sync_ff <= '0;
      pwr_sync_ff <= '0;
      mute_sync_ff <= '0;
      lat_sync_ff <= '0;
      clk_sync_ff <= '0;
      dat_sync_ff <= '0;
    end
    else
    begin
      tgl_sync_ff <= {tgl_sync_ff[1:0], word_tgl_ff};
      mode_sync_ff <= {mode_sync_ff[0], mode_pin};
      pwr_sync_ff <= {pwr_sync_ff[0], power_off_pin};
      mute_sync_ff <= {mute_sync_ff[0], mute_pin_in};
      lat_sync_ff <= {lat_sync_ff[0], ctl_latch_or_format_pin};
      clk_sync_ff <= {clk_sync_ff[0], ctl_clock_or_width_pin};
      dat_sync_ff <= {dat_sync_ff[0], ctl_data_or_deemph_pin};
    end
  end

  // Word is stable in word_ff well before the toggle is seen
  assign word_evt = tgl_sync_ff[2] ^ tgl_sync_ff[1];

  // ****************************************
  // Program registers
  // ****************************************
  logic [7:0] left_level_ff, right_level_ff;
  logic [7:0] left_applied_ff, right_applied_ff;
  dacctl_out_s out_reg_ff;
  dacctl_fmt_s fmt_reg_ff;
  logic [1:0] waddr;

  assign waddr = word_ff[`DACCTL_ADDR_HI:`DACCTL_ADDR_LO];

  // Store levels; apply when commit bit set
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      left_level_ff <= `DACCTL_LEVEL_RST;
      right_level_ff <= `DACCTL_LEVEL_RST;
      left_applied_ff <= `DACCTL_LEVEL_RST;
      right_applied_ff <= `DACCTL_LEVEL_RST;
    end
    else if (word_evt && waddr == `DACCTL_REG_LEFT)
    begin
      left_level_ff <= word_ff[7:0];
      if (word_ff[`DACCTL_COMMIT_BIT])
        left_applied_ff <= word_ff[7:0];
    end
    else if (word_evt && waddr == `DACCTL_REG_RIGHT)
    begin
      right_level_ff <= word_ff[7:0];
      if (word_ff[`DACCTL_COMMIT_BIT])
        right_applied_ff <= word_ff[7:0];
    end
  end

  // Output and format control registers
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      out_reg_ff <= '{soft_silence: 1'b0, deemph_enable: 1'b0, dac_disable: 1'b0,
                     sample_width: `DACCTL_WIDTH_16, output_routing: `DACCTL_ROUTE_RST};
      fmt_reg_ff <= '0;
    end
    else if (word_evt && waddr == `DACCTL_REG_OUT)
      out_reg_ff <= {word_ff[0], word_ff[1], word_ff[2], word_ff[4:3], word_ff[8:5]};
    else if (word_evt && waddr == `DACCTL_REG_FMT)
      fmt_reg_ff <= {word_ff[0], word_ff[1], word_ff[2], word_ff[7:6], word_ff[8]};
  end

  // ****************************************
  // Effective configuration, hardware or software mode
  // ****************************************
  logic hw_mode, eff_i2s, eff_deemph, eff_shared;
  logic [1:0] eff_width;
  logic [7:0] eff_left_level, eff_right_level;

  always_comb
  begin
    hw_mode = mode_sync_ff[1];
    if (hw_mode)
    begin
      eff_i2s = lat_sync_ff[1] & clk_sync_ff[1];
      case ({lat_sync_ff[1], clk_sync_ff[1]})
        2'h1: eff_width = `DACCTL_WIDTH_20;
        2'h2: eff_width = `DACCTL_WIDTH_24;
        2'h3: eff_width = `DACCTL_WIDTH_24; // I2S takes any length
        default: eff_width = `DACCTL_WIDTH_16;
      endcase
      eff_deemph = dat_sync_ff[1];
      eff_shared = 1'b0;
      eff_left_level = `DACCTL_LEVEL_RST;
      eff_right_level = `DACCTL_LEVEL_RST;
    end
    else
    begin
      eff_i2s = fmt_reg_ff.i2s_format;
      eff_width = out_reg_ff.sample_width;
      eff_deemph = out_reg_ff.deemph_enable;
      eff_shared = fmt_reg_ff.shared_level;
      eff_left_level = left_applied_ff;
      eff_right_level = eff_shared ? left_applied_ff : right_applied_ff;
    end
  end

  // ****************************************
  // Automute detector
  // ****************************************
  logic [$clog2(ZERO_RUN+1)-1:0] zero_cnt_ff;
  logic automuted_ff;

  // Count zero pairs; nonzero restarts and clears latch
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      zero_cnt_ff <= '0;
      automuted_ff <= 1'b0;
    end
    else if (sample_valid)
    begin
      if (sample_left != '0 || sample_right != '0)
      begin
        zero_cnt_ff <= '0;
        automuted_ff <= 1'b0;
      end
      else if (zero_cnt_ff == ($clog2(ZERO_RUN+1))'(ZERO_RUN - 1))
      begin
        zero_cnt_ff <= ($clog2(ZERO_RUN+1))'(ZERO_RUN);
        automuted_ff <= 1'b1;
      end
      else if (!automuted_ff)
        zero_cnt_ff <= zero_cnt_ff + 1'b1;
    end
  end

  // Weak drive of mute pin: pull high only while latched
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      mute_pin_out_ff <= 1'b0;
      mute_pin_oe_n_ff <= 1'b1;
    end
    else
    begin
      mute_pin_out_ff <= 1'b1;
      mute_pin_oe_n_ff <= ~automuted_ff;
    end
  end

  // ****************************************
  // Soft mute ramp and output stage
  // ****************************************
  logic mute_req;
  logic [$clog2(RAMP_STEP_CYC+1)-1:0] ramp_cnt_ff;

  // Pin, register bit in software mode and qualified automute all request silence
  assign mute_req = mute_sync_ff[1] | (~hw_mode & out_reg_ff.soft_silence)
                  | (automuted_ff & (hw_mode | fmt_reg_ff.zero_detect_enable));

  // Ramp gain down or up one step per interval, no click
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      ramp_cnt_ff <= '0;
      silence_gain_ff <= 8'hff;
    end
    else if (ramp_cnt_ff == ($clog2(RAMP_STEP_CYC+1))'(RAMP_STEP_CYC - 1))
    begin
      ramp_cnt_ff <= '0;
      if (mute_req && silence_gain_ff != 8'h00)
        silence_gain_ff <= silence_gain_ff - 8'h01;
      else if (!mute_req && silence_gain_ff != 8'hff)
        silence_gain_ff <= silence_gain_ff + 8'h01;
    end
    else
      ramp_cnt_ff <= ramp_cnt_ff + 1'b1;
  end

  logic [7:0] gl, gr;
  logic [1:0] sel_l, sel_r;
  logic idle;

  // Combine level and ramp gain, pick routing codes
  always_comb
  begin
    gl = 8'(({8'h00, eff_left_level} * {8'h00, silence_gain_ff}) >> 8);
    gr = 8'(({8'h00, eff_right_level} * {8'h00, silence_gain_ff}) >> 8);
    if (eff_left_level == 8'hff)
      gl = silence_gain_ff;
    if (eff_right_level == 8'hff)
      gr = silence_gain_ff;
    // Full ramp gain passes the programmed level unchanged
    if (silence_gain_ff == 8'hff)
    begin
      gl = eff_left_level;
      gr = eff_right_level;
    end
    sel_l = hw_mode ? 2'h1 : out_reg_ff.output_routing[1:0];
    sel_r = hw_mode ? 2'h2 : out_reg_ff.output_routing[3:2];
    idle = pwr_sync_ff[1] | (~hw_mode & out_reg_ff.dac_disable);
  end

  dacctl_chan #(.SW(SW)) u_left (
    .mclk(mclk), .reset(reset), .left_in(sample_left), .right_in(sample_right),
    .sel(sel_l), .level(gl), .silent(idle), .out_ff(dac_left_ff)
  );

  dacctl_chan #(.SW(SW)) u_right (
    .mclk(mclk), .reset(reset), .left_in(sample_left), .right_in(sample_right),
    .sel(sel_r), .level(gr), .silent(idle), .out_ff(dac_right_ff)
  );

  // Status outputs
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      dac_midrail_ff <= 1'b0;
      powered_down_ff <= 1'b0;
      deemph_on_ff <= 1'b0;
      i2s_mode_ff <= 1'b0;
      sample_width_ff <= `DACCTL_WIDTH_16;
      rate_group_ff <= 2'h0;
      left_is_high_ff <= 1'b1;
      automute_ff <= 1'b0;
    end
    else
    begin
      dac_midrail_ff <= idle;
      powered_down_ff <= pwr_sync_ff[1];
      deemph_on_ff <= eff_deemph;
      i2s_mode_ff <= eff_i2s;
      sample_width_ff <= eff_width;
      rate_group_ff <= hw_mode ? 2'h0 : fmt_reg_ff.rate_group;
      left_is_high_ff <= hw_mode | ~fmt_reg_ff.frame_polarity;
      automute_ff <= automuted_ff;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_zero_pair;
    sample_valid && sample_left == '0 && sample_right == '0;
  endsequence

  a_nonzero_clears: assert property (@(posedge mclk) disable iff (reset)
    sample_valid && (sample_left != '0 || sample_right != '0) |=> !automuted_ff && zero_cnt_ff == '0)
    else $error("nonzero sample did not clear automute");

  a_latch_sets: assert property (@(posedge mclk) disable iff (reset)
    s_zero_pair ##0 (zero_cnt_ff == ($clog2(ZERO_RUN+1))'(ZERO_RUN - 1)) |=> automuted_ff)
    else $error("automute latch not set at run end");

  a_weak_drive: assert property (@(posedge mclk) disable iff (reset)
    automuted_ff |=> !mute_pin_oe_n_ff && mute_pin_out_ff)
    else $error("automute not driven on mute pin");

  a_pin_mutes: assert property (@(posedge mclk) disable iff (reset)
    mute_sync_ff[1] && ramp_cnt_ff == ($clog2(RAMP_STEP_CYC+1))'(RAMP_STEP_CYC - 1) && silence_gain_ff != 8'h00
    |=> silence_gain_ff == $past(silence_gain_ff) - 8'h01)
    else $error("mute pin did not ramp gain down");

  a_qualified_mute: assert property (@(posedge mclk) disable iff (reset)
    !hw_mode && !mute_sync_ff[1] && !out_reg_ff.soft_silence && !fmt_reg_ff.zero_detect_enable |-> !mute_req)
    else $error("unqualified automute reached soft mute");

  a_commit_hold: assert property (@(posedge mclk) disable iff (reset)
    word_evt && waddr == `DACCTL_REG_LEFT && !word_ff[`DACCTL_COMMIT_BIT] |=> $stable(left_applied_ff))
    else $error("uncommitted level applied");

  a_power_down: assert property (@(posedge mclk) disable iff (reset)
    pwr_sync_ff[1] |=> dac_midrail_ff && powered_down_ff && dac_left_ff == '0 && dac_right_ff == '0)
    else $error("powerdown did not idle outputs");

  a_shared_level: assert property (@(posedge mclk) disable iff (reset)
    !hw_mode && fmt_reg_ff.shared_level |-> eff_right_level == left_applied_ff)
    else $error("shared level not applied to right");

  a_hw_format: assert property (@(posedge mclk) disable iff (reset)
    hw_mode && lat_sync_ff[1] && !clk_sync_ff[1] |=> !i2s_mode_ff && sample_width_ff == `DACCTL_WIDTH_24)
    else $error("hardware format code misdecoded");
endmodule : dacctl_top

// File: testbench/dacctl_host_model.sv
// Host model that drives the 3-wire control port of the DAC
module dacctl_host_model
(
  // Control pins toward the device
  output logic ctl_clk,
  output logic ctl_data,
  output logic ctl_latch
);
  timeunit 1ns;
  timeprecision 100ps;

  // Shift clock idles low between frames
  initial
  begin
    ctl_clk = 1'b0;
    ctl_data = 1'b0;
    ctl_latch = 1'b0;
  end

  // Shift a word MSB first with an 80 ns shift clock, then strobe the latch
  task automatic send(input logic [15:0] word);
    #13;
    for (int i = 15; i >= 0; i--)
    begin
      ctl_data = word[i];
      #40 ctl_clk = 1'b1;
      #40 ctl_clk = 1'b0;
    end
    ctl_data = ~word[0]; // Data is stale once the frame ends
    #40 ctl_latch = 1'b1;
    #80 ctl_latch = 1'b0;
    #40;
  endtask : send

  // Static pin levels used in hardware mode
  task automatic set_static(input logic latch_v, input logic clk_v, input logic data_v);
    ctl_latch = latch_v;
    ctl_clk = clk_v;
    ctl_data = data_v;
  endtask : set_static
endmodule : dacctl_host_model

// File: testbench/tb_dac_control_port_and_mute.sv
// Self-checking testbench of the DAC control port and mute block
`define CHECK(act, exp) \
  begin \
    comparisons++; \
    if ((act) !== (exp)) \
    begin \
      failures++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp); \
    end \
  end
module tb_dac_control_port_and_mute;
  import dacctl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic signed [23:0] SL = 24'sh000100;
  localparam logic signed [23:0] SR = 24'sh000200;
  logic mclk, reset, mode_pin, power_off_pin, mute_pin_in, sample_valid, ext_en, ext_val;
  logic ctl_clk, ctl_data, ctl_latch, mute_out, mute_oe_n, midrail, pwd, deemph, i2s, lhigh, automute;
  logic signed [23:0] sample_left, sample_right, dac_left, dac_right;
  logic [1:0] width, rate;
  logic [7:0] gain;
  int failures = 0;
  int comparisons = 0;

  // Mute pin: outside driver wins, else the weak automute drive, else low
  assign mute_pin_in = ext_en ? ext_val : (!mute_oe_n & mute_out);

  dacctl_host_model dacctl_host_model_inst (.ctl_clk(ctl_clk), .ctl_data(ctl_data), .ctl_latch(ctl_latch));

  dacctl_top #(.SW(24), .ZERO_RUN(8), .RAMP_STEP_CYC(2)) dacctl_top_inst (
    .mclk(mclk), .reset(reset), .ctl_clock_or_width_pin(ctl_clk), .ctl_data_or_deemph_pin(ctl_data),
    .ctl_latch_or_format_pin(ctl_latch), .mode_pin(mode_pin), .power_off_pin(power_off_pin),
    .mute_pin_in(mute_pin_in), .mute_pin_out_ff(mute_out), .mute_pin_oe_n_ff(mute_oe_n),
    .sample_valid(sample_valid), .sample_left(sample_left), .sample_right(sample_right), .frame_sync(1'b1),
    .dac_left_ff(dac_left), .dac_right_ff(dac_right), .dac_midrail_ff(midrail), .powered_down_ff(pwd),
    .deemph_on_ff(deemph), .i2s_mode_ff(i2s), .sample_width_ff(width), .rate_group_ff(rate),
    .left_is_high_ff(lhigh), .automute_ff(automute), .silence_gain_ff(gain));

  // 20 MHz system clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Write one register and let it cross into the system domain
  task automatic wr(input logic [1:0] addr, input logic [8:0] data);
    dacctl_host_model_inst.send({5'h00, addr, data});
    repeat (8) @(negedge mclk);
  endtask : wr

  // Send one stereo pair and compare the processed outputs
  task automatic pair(input logic signed [23:0] l, input logic signed [23:0] r,
                      input logic signed [23:0] el, input logic signed [23:0] er);
    @(negedge mclk);
    sample_left = l;
    sample_right = r;
    sample_valid = 1'b1;
    @(negedge mclk);
    sample_valid = 1'b0;
    repeat (4) @(negedge mclk);
    `CHECK(dac_left, el)
    `CHECK(dac_right, er)
  endtask : pair

  // Expected output for one routing select
  function automatic logic signed [23:0] pick(input logic [1:0] s);
    case (s)
      2'h0: pick = 24'sh000000;
      2'h1: pick = SL;
      2'h2: pick = SR;
      default: pick = 24'sh000180;
    endcase
  endfunction : pick

  task automatic results;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // Watchdog well beyond the expected run of about 0.27 ms
  initial
  begin
    #3000000;
    failures++;
    results();
  end

  // Test sequence
  initial
  begin
    reset = 1'b1;
    {mode_pin, power_off_pin, sample_valid, ext_en, ext_val} = 5'h00;
    sample_left = 24'sh0;
    sample_right = 24'sh0;
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    repeat (2) @(negedge mclk);
    `CHECK({width, rate, deemph, i2s, midrail, pwd, lhigh, automute}, 10'h002)
    `CHECK({gain, mute_oe_n}, 9'h1ff)
    pair(SL, SR, SL, SR);
    $display("test reset values done");
    for (int w = 0; w < 4; w++)
    begin
      wr(2'h2, {4'h9, w[1:0], 3'h0});
      `CHECK(width, w[1:0])
    end
    wr(2'h2, 9'h122);
    `CHECK({deemph, midrail}, 2'h2)
    wr(2'h2, 9'h124);
    `CHECK({deemph, midrail}, 2'h1)
    pair(SL, SR, 24'sh0, 24'sh0);
    for (int r = 0; r < 16; r++)
    begin
      wr(2'h2, {r[3:0], 5'h00});
      pair(SL, SR, pick(r[1:0]), pick(r[3:2]));
    end
    wr(2'h2, 9'h120);
    $display("test output register done");
    for (int g = 0; g < 4; g++)
    begin
      wr(2'h3, {1'b0, g[1:0], 6'h00});
      `CHECK(rate, g[1:0])
    end
    wr(2'h3, 9'h003);
    `CHECK({lhigh, i2s}, 2'h1)
    wr(2'h3, 9'h000);
    `CHECK({lhigh, i2s}, 2'h2)
    $display("test format register done");
    wr(2'h0, 9'h080);
    pair(SL, SR, SL, SR);
    wr(2'h0, 9'h180);
    pair(SL, SR, 24'sh000080, SR);
    wr(2'h1, 9'h100);
    pair(SL, SR, 24'sh000080, 24'sh0);
    wr(2'h3, 9'h004);
    pair(SL, SR, 24'sh000080, 24'sh000100);
    wr(2'h3, 9'h000);
    wr(2'h0, 9'h1ff);
    wr(2'h1, 9'h1ff);
    pair(SL, SR, SL, SR);
    $display("test levels done");
    mode_pin = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      dacctl_host_model_inst.set_static(c[1], c[0], c[0]);
      repeat (8) @(negedge mclk);
      `CHECK(width, (c == 3) ? 2'h2 : c[1:0])
      `CHECK(i2s, (c == 3))
      `CHECK(deemph, c[0])
    end
    dacctl_host_model_inst.set_static(1'b0, 1'b0, 1'b0);
    mode_pin = 1'b0;
    repeat (8) @(negedge mclk);
    $display("test hardware mode done");
    power_off_pin = 1'b1;
    repeat (4) @(negedge mclk);
    `CHECK(pwd, 1'b1)
    pair(SL, SR, 24'sh0, 24'sh0);
    power_off_pin = 1'b0;
    repeat (4) @(negedge mclk);
    `CHECK(pwd, 1'b0)
    $display("test power down done");
    ext_en = 1'b1;
    ext_val = 1'b1;
    repeat (600) @(negedge mclk);
    `CHECK(gain, 8'h00)
    ext_val = 1'b0;
    repeat (600) @(negedge mclk);
    `CHECK(gain, 8'hff)
    wr(2'h2, 9'h121);
    repeat (600) @(negedge mclk);
    `CHECK(gain, 8'h00)
    wr(2'h2, 9'h120);
    repeat (600) @(negedge mclk);
    `CHECK(gain, 8'hff)
    $display("test mute ramp done");
    ext_en = 1'b0;
    wr(2'h3, 9'h100);
    repeat (7) pair(24'sh0, 24'sh0, 24'sh0, 24'sh0);
    pair(SL, 24'sh0, SL, 24'sh0);
    repeat (7) pair(24'sh0, 24'sh0, 24'sh0, 24'sh0);
    `CHECK(automute, 1'b0)
    pair(24'sh0, 24'sh0, 24'sh0, 24'sh0);
    `CHECK({automute, mute_oe_n, mute_out}, 3'h5)
    repeat (600) @(negedge mclk);
    `CHECK(gain, 8'h00)
    pair(SL, SR, 24'sh0, 24'sh0);
    `CHECK({automute, mute_oe_n}, 2'h1)
    repeat (600) @(negedge mclk);
    `CHECK({dac_left, dac_right}, {SL, SR})
    $display("test automute done");
    results();
  end
endmodule : tb_dac_control_port_and_mute
